// file: common/sbr_pkg.sv
// Purpose: Shared constants and types for the block-read responder
// Assumes: 25 MHz core clock, SMBus at up to 100 kHz
// Notes: Widths fixed; link addresses are the 7-bit forms of the read bytes
package sbr_pkg;

    localparam int          BYTE_W        = 8;
    localparam int          BUF_AW        = 10;
    localparam int          FIFO_DEPTH    = 2;
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          T_DH_NS       = 300;
    // Least hold time rounds up to whole cycles
    localparam logic [3:0]  DH_CYC        = 4'((T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [6:0]  SLV_ADDR_CONT  = 7'h28;
    localparam logic [6:0]  SLV_ADDR_FIRST = 7'h29;
    localparam logic [7:0]  EMPTY_BYTE    = 8'hff;

    typedef enum logic [2:0] {
        SBR_IDLE     = 3'h0,
        SBR_ADDR     = 3'h1,
        SBR_ADDR_ACK = 3'h3,
        SBR_TX       = 3'h2,
        SBR_TX_ACK   = 3'h6,
        SBR_WR_BYTE  = 3'h7,
        SBR_WR_ACK   = 3'h5
    } sbr_state_t;

    typedef struct packed {
        sbr_state_t          state;
        logic [3:0]          bcnt;
        logic [3:0]          dly;
        logic                is_read;
        logic                restart;
        logic                ack_seen;
        logic                fresh;
        logic [7:0]          tx_sr;
        logic [7:0]          tx_left;
        logic [7:0]          fetch_left;
        logic [BUF_AW-1:0]   ptr;
        logic [BUF_AW-1:0]   fetch_ptr;
        logic [BUF_AW-1:0]   mem_addr;
        logic                mem_rd;
        logic                pend;
        logic                sda_oe;
        logic                sda_out;
        logic                scl_s1;
        logic                scl_s2;
        logic                scl_d;
        logic                sda_s1;
        logic                sda_s2;
        logic                sda_d;
    } sbr_regs_t;

    localparam sbr_regs_t   REGS_RST      = '0;

endpackage

// file: hw/sbr_fifo2.sv
// Purpose: Small valid/ready buffer between buffer fetch and link transmitter
// Assumes: Single clock, synchronous active-low reset
// Notes: Flush wins over push and pop in the same cycle
`timescale 1ns/1ps
module sbr_fifo2 #(
    parameter int WIDTH = sbr_pkg::BYTE_W,
    parameter int DEPTH = sbr_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } sbr_fifo_regs_t;

    sbr_fifo_regs_t r_reg;
    sbr_fifo_regs_t r_next;
    logic           do_push;
    logic           do_pop;

    assign in_ready  = (r_reg.cnt != CW'(DEPTH));
    assign out_valid = (r_reg.cnt != '0);
    assign out_data  = r_reg.mem[r_reg.rp];

    always_comb begin
        r_next  = r_reg;
        do_push = in_valid && in_ready;
        do_pop  = out_valid && out_ready;
        if (do_push) begin
            r_next.mem[r_reg.wp] = in_data;
            r_next.wp = (r_reg.wp == PW'(DEPTH - 1)) ? '0 : r_reg.wp + PW'(1);
        end
        if (do_pop) begin
            r_next.rp = (r_reg.rp == PW'(DEPTH - 1)) ? '0 : r_reg.rp + PW'(1);
        end
        if (do_push && !do_pop) begin
            r_next.cnt = r_reg.cnt + CW'(1);
        end else if (do_pop && !do_push) begin
            r_next.cnt = r_reg.cnt - CW'(1);
        end
        if (flush) begin
            r_next.wp  = '0;
            r_next.rp  = '0;
            r_next.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    chk_no_overflow: assert property (@(posedge clk) disable iff (!reset_n)
        r_reg.cnt <= CW'(DEPTH)) else $error("Buffer count above depth");

endmodule // sbr_fifo2

// file: hw/sbr_block_read.sv
// Purpose: SMBus slave read path that streams the I/O buffer out in counted blocks
// Assumes: scl_clk and scl_i both carry the SCL pin; buffer memory answers one cycle after mem_rd
// Notes: Byte framing runs on the core clock from synchronised pins; bit capture runs on SCL
`timescale 1ns/1ps
module sbr_block_read (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        scl_clk,
    input  wire logic                        scl_i,
    input  wire logic                        sda_i,
    output logic                             sda_o,
    output logic                             sda_oe,
    input  wire logic [sbr_pkg::BUF_AW:0]    buf_len,
    input  wire logic [7:0]                  max_read_block_size,
    input  wire logic                        load_done,
    output logic                             mem_rd,
    output logic [sbr_pkg::BUF_AW-1:0]       mem_addr,
    input  wire logic [7:0]                  mem_rdata
);
    sbr_pkg::sbr_regs_t r_reg;
    sbr_pkg::sbr_regs_t r_next;
    logic [7:0]         rx_sr_reg;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_cond;
    logic               stop_cond;
    logic               fall_act;
    logic               sess_start;
    logic [sbr_pkg::BUF_AW-1:0] sess_base;
    logic [7:0]         sess_count;
    logic               fifo_flush;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic               fifo_out_ready;
    logic [7:0]         fifo_out_data;
    logic [7:0]         next_byte;

    function automatic logic [sbr_pkg::BUF_AW-1:0] ptr_inc(
        input logic [sbr_pkg::BUF_AW-1:0] p,
        input logic [sbr_pkg::BUF_AW:0]   len
    );
        logic [sbr_pkg::BUF_AW:0] nx;
        nx = {1'b0, p} + {{sbr_pkg::BUF_AW{1'b0}}, 1'b1};
        return (nx >= len) ? '0 : nx[sbr_pkg::BUF_AW-1:0];
    endfunction

    function automatic logic [7:0] block_count(
        input logic [sbr_pkg::BUF_AW-1:0] base,
        input logic [sbr_pkg::BUF_AW:0]   len,
        input logic [7:0]                 lim
    );
        logic [sbr_pkg::BUF_AW:0] left;
        left = (len > {1'b0, base}) ? len - {1'b0, base} : '0;
        return (left > {3'h0, lim}) ? lim : left[7:0];
    endfunction

    // Bit capture on the link clock; framing reads it only while SCL is low
    always_ff @(posedge scl_clk) begin
        rx_sr_reg <= {rx_sr_reg[6:0], sda_i};
    end

    assign scl_rise   = r_reg.scl_s2 && !r_reg.scl_d;
    assign scl_fall   = !r_reg.scl_s2 && r_reg.scl_d;
    assign start_cond = r_reg.scl_s2 && r_reg.scl_d && r_reg.sda_d && !r_reg.sda_s2;
    assign stop_cond  = r_reg.scl_s2 && r_reg.scl_d && !r_reg.sda_d && r_reg.sda_s2;
    // Delayed fall keeps our data change clear of the output hold window
    assign fall_act   = (r_reg.dly == 4'h1);
    assign sess_start = (r_reg.state == sbr_pkg::SBR_ADDR_ACK) && fall_act && r_reg.is_read
                        && !start_cond && !stop_cond;
    assign sess_base  = (r_reg.restart || r_reg.fresh) ? '0 : r_reg.ptr;
    assign sess_count = block_count(sess_base, buf_len, max_read_block_size);
    assign next_byte  = fifo_out_valid ? fifo_out_data : sbr_pkg::EMPTY_BYTE;

    always_comb begin
        r_next         = r_reg;
        fifo_flush     = 1'b0;
        fifo_out_ready = 1'b0;
        r_next.scl_s1  = scl_i;
        r_next.scl_s2  = r_reg.scl_s1;
        r_next.scl_d   = r_reg.scl_s2;
        r_next.sda_s1  = sda_i;
        r_next.sda_s2  = r_reg.sda_s1;
        r_next.sda_d   = r_reg.sda_s2;
        r_next.sda_out = 1'b0;
        r_next.mem_rd  = 1'b0;
        r_next.pend    = r_reg.mem_rd;
        if (scl_fall) begin
            r_next.dly = sbr_pkg::DH_CYC;
        end else if (r_reg.dly != 4'h0) begin
            r_next.dly = r_reg.dly - 4'h1;
        end
        // Prefetch one byte at a time so a returning word always has a slot
        if (r_reg.fetch_left != 8'h0 && fifo_in_ready && !r_reg.mem_rd && !r_reg.pend) begin
            r_next.mem_rd     = 1'b1;
            r_next.mem_addr   = r_reg.fetch_ptr;
            r_next.fetch_ptr  = ptr_inc(r_reg.fetch_ptr, buf_len);
            r_next.fetch_left = r_reg.fetch_left - 8'h1;
        end
        // A new frame ends any prefetch left over from a block the host cut short
        if (start_cond) begin
            r_next.state      = sbr_pkg::SBR_ADDR;
            r_next.bcnt       = 4'h0;
            r_next.sda_oe     = 1'b0;
            r_next.fetch_left = 8'h0;
        end else if (stop_cond) begin
            r_next.state      = sbr_pkg::SBR_IDLE;
            r_next.sda_oe     = 1'b0;
            r_next.fetch_left = 8'h0;
        end else begin
            unique case (r_reg.state)
                sbr_pkg::SBR_IDLE: begin
                end
                sbr_pkg::SBR_ADDR, sbr_pkg::SBR_WR_BYTE: begin
                    if (scl_rise) begin
                        r_next.bcnt = r_reg.bcnt + 4'h1;
                    end
                    if (fall_act && r_reg.bcnt == sbr_pkg::BITS_PER_BYTE) begin
                        if (r_reg.state == sbr_pkg::SBR_WR_BYTE) begin
                            // Ignored write bytes are acked and dropped
                            r_next.sda_oe = 1'b1;
                            r_next.state  = sbr_pkg::SBR_WR_ACK;
                        end else if (rx_sr_reg[7:1] == sbr_pkg::SLV_ADDR_FIRST ||
                                     rx_sr_reg[7:1] == sbr_pkg::SLV_ADDR_CONT) begin
                            r_next.sda_oe  = 1'b1;
                            r_next.state   = sbr_pkg::SBR_ADDR_ACK;
                            r_next.is_read = rx_sr_reg[0];
                            r_next.restart = (rx_sr_reg[7:1] == sbr_pkg::SLV_ADDR_FIRST);
                        end else begin
                            r_next.state = sbr_pkg::SBR_IDLE;
                        end
                    end
                end
                sbr_pkg::SBR_ADDR_ACK: begin
                    if (fall_act) begin
                        r_next.sda_oe = 1'b0;
                        if (sess_start) begin
                            // Count byte goes out first, with no command from host
                            r_next.ptr        = sess_base;
                            r_next.fetch_ptr  = sess_base;
                            r_next.fetch_left = sess_count;
                            r_next.tx_left    = sess_count;
                            r_next.tx_sr      = sess_count;
                            r_next.sda_oe     = !sess_count[7];
                            r_next.bcnt       = 4'h1;
                            r_next.fresh      = 1'b0;
                            r_next.mem_rd     = 1'b0;
                            r_next.pend       = 1'b0;
                            fifo_flush        = 1'b1;
                            r_next.state      = sbr_pkg::SBR_TX;
                        end else begin
                            r_next.bcnt  = 4'h0;
                            r_next.state = sbr_pkg::SBR_WR_BYTE;
                        end
                    end
                end
                sbr_pkg::SBR_TX: begin
                    if (fall_act) begin
                        if (r_reg.bcnt == sbr_pkg::BITS_PER_BYTE) begin
                            r_next.sda_oe = 1'b0;
                            r_next.state  = sbr_pkg::SBR_TX_ACK;
                        end else begin
                            r_next.tx_sr  = {r_reg.tx_sr[6:0], 1'b0};
                            r_next.sda_oe = !r_reg.tx_sr[6];
                            r_next.bcnt   = r_reg.bcnt + 4'h1;
                        end
                    end
                end
                sbr_pkg::SBR_TX_ACK: begin
                    if (scl_rise) begin
                        r_next.ack_seen = !r_reg.sda_s2;
                    end
                    if (fall_act) begin
                        if (r_reg.ack_seen && r_reg.tx_left != 8'h0) begin
                            fifo_out_ready = 1'b1;
                            r_next.tx_sr   = next_byte;
                            r_next.sda_oe  = !next_byte[7];
                            r_next.bcnt    = 4'h1;
                            r_next.tx_left = r_reg.tx_left - 8'h1;
                            // Wrap is silent; only the next count shows it
                            r_next.ptr     = ptr_inc(r_reg.ptr, buf_len);
                            r_next.state   = sbr_pkg::SBR_TX;
                        end else begin
                            // Host nack or overrun ends the block and frees the bus
                            r_next.state = sbr_pkg::SBR_IDLE;
                        end
                    end
                end
                sbr_pkg::SBR_WR_ACK: begin
                    if (fall_act) begin
                        r_next.sda_oe = 1'b0;
                        r_next.bcnt   = 4'h0;
                        r_next.state  = sbr_pkg::SBR_WR_BYTE;
                    end
                end
                default: begin
                    r_next.state  = sbr_pkg::SBR_IDLE;
                    r_next.sda_oe = 1'b0;
                end
            endcase
        end
        // New buffer contents win over the clear at session start
        if (load_done) begin
            r_next.fresh = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r_reg <= sbr_pkg::REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    sbr_fifo2 #(
        .WIDTH (sbr_pkg::BYTE_W),
        .DEPTH (sbr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .flush     (fifo_flush),
        .in_valid  (r_reg.pend),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_rdata),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign sda_o    = r_reg.sda_out;
    assign sda_oe   = r_reg.sda_oe;
    assign mem_rd   = r_reg.mem_rd;
    assign mem_addr = r_reg.mem_addr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_first_from_zero: assert property (
        sess_start && r_reg.restart |=> r_reg.ptr == '0 && r_reg.fetch_ptr == '0)
        else $error("Read-first block did not start at zero");

    chk_continue_resumes: assert property (
        sess_start && !r_reg.restart && !r_reg.fresh |=> r_reg.ptr == $past(r_reg.ptr))
        else $error("Continue read lost its position");

    chk_fresh_acts_first: assert property (
        sess_start && r_reg.fresh |=> r_reg.ptr == '0 && (!r_reg.fresh || $past(load_done)))
        else $error("Continue read after load did not restart");

    chk_count_bounded: assert property (
        sess_start |=> r_reg.tx_left <= $past(max_read_block_size)
                       && {3'h0, r_reg.tx_left} <= $past(buf_len) && r_reg.tx_sr == r_reg.tx_left)
        else $error("Count byte exceeds limit or unread bytes");

    chk_pointer_wrap: assert property (
        fifo_out_ready && {1'b0, r_reg.ptr} + 11'h1 == buf_len |=> r_reg.ptr == '0)
        else $error("Pointer did not wrap after final byte");

    chk_write_ignored: assert property (
        r_reg.state == sbr_pkg::SBR_WR_BYTE || r_reg.state == sbr_pkg::SBR_WR_ACK
        |=> $stable(r_reg.ptr) && r_reg.fetch_left == 8'h0 || start_cond)
        else $error("Ignored write moved the read pointer");

    chk_msb_order: assert property (
        r_reg.state == sbr_pkg::SBR_TX && fall_act && r_reg.bcnt < 4'h8 && !start_cond && !stop_cond
        |=> r_reg.sda_oe == !$past(r_reg.tx_sr[6]))
        else $error("Transmit bit order broken");

    chk_slave_quiet: assert property (
        r_reg.scl_s2 && r_reg.scl_d |-> $stable(r_reg.sda_oe))
        else $error("Device changed SDA while SCL high");

    chk_data_hold: assert property (
        scl_fall |-> !$changed(r_reg.sda_oe) [*7])
        else $error("Data changed inside hold window");

    // Between frames the bus belongs to the host
    chk_idle_released: assert property (
        r_reg.state == sbr_pkg::SBR_IDLE |-> !r_reg.sda_oe)
        else $error("Idle responder still pulls SDA");

    chk_wr_quiet: assert property (
        r_reg.state == sbr_pkg::SBR_WR_BYTE |-> !r_reg.sda_oe)
        else $error("Ignored write byte was driven");

    chk_ack_released: assert property (
        r_reg.state == sbr_pkg::SBR_TX_ACK |-> !r_reg.sda_oe)
        else $error("SDA held during host acknowledge");

    chk_count_first: assert property (
        sess_start |=> r_reg.state == sbr_pkg::SBR_TX && r_reg.bcnt == 4'h1 && r_reg.sda_oe == !r_reg.tx_sr[7])
        else $error("Count byte did not lead the block");

    chk_block_length: assert property (
        r_reg.state == sbr_pkg::SBR_TX_ACK && fall_act && r_reg.tx_left == 8'h0 && !start_cond && !stop_cond
        |=> r_reg.state == sbr_pkg::SBR_IDLE)
        else $error("Block ran past its count");

    chk_nack_ends: assert property (
        r_reg.state == sbr_pkg::SBR_TX_ACK && fall_act && !r_reg.ack_seen && !start_cond && !stop_cond
        |=> r_reg.state == sbr_pkg::SBR_IDLE && !r_reg.sda_oe)
        else $error("Host nack did not end the block");

    chk_foreign_refused: assert property (
        r_reg.state == sbr_pkg::SBR_ADDR && fall_act && r_reg.bcnt == sbr_pkg::BITS_PER_BYTE && !start_cond
        && !stop_cond && rx_sr_reg[7:1] != sbr_pkg::SLV_ADDR_FIRST && rx_sr_reg[7:1] != sbr_pkg::SLV_ADDR_CONT
        |=> r_reg.state == sbr_pkg::SBR_IDLE && !r_reg.sda_oe)
        else $error("Foreign address was answered");

    chk_fresh_sets: assert property (
        load_done |=> r_reg.fresh)
        else $error("Buffer load did not mark a fresh start");

    // One read in flight keeps a buffer slot free for every answer
    chk_fetch_spacing: assert property (
        r_reg.mem_rd |=> !r_reg.mem_rd ##1 !r_reg.mem_rd)
        else $error("Buffer reads too close together");

    chk_fetch_order: assert property (
        r_reg.mem_rd |-> r_reg.fetch_ptr == ptr_inc(r_reg.mem_addr, buf_len))
        else $error("Buffer fetched out of order");

    // Fetch must stay ahead of the link; a miss would send filler bytes
    chk_no_underrun: assert property (
        fifo_out_ready |-> fifo_out_valid)
        else $error("Data byte needed before it was fetched");

endmodule // sbr_block_read

// file: verif/sbr_host_model.sv
// Purpose: Behavioural SMBus host that drives SCL and pulls SDA low for the responder bench
// Assumes: Both lines have pull-ups; the bench resolves the SDA wire from every party's pull
// Notes: SCL runs faster than the bus limit to keep runs short; its low phase still dwarfs the drive delay
`timescale 1ns/1ps
module sbr_host_model #(
    parameter int HALF_NS = 1000
) (
    output logic      scl,
    output logic      host_oe,
    input  wire logic sda
);

    // SCL stands high between frames
    initial begin
        scl     = 1'b1;
        host_oe = 1'b0;
    end

    // Host is master and makes every start, repeated start and stop
    task automatic start();
        if (!scl) begin
            host_oe = 1'b0;
            #(HALF_NS / 2);
            scl = 1'b1;
        end
        #(HALF_NS);
        host_oe = 1'b1;
        #(HALF_NS);
        scl = 1'b0;
    endtask

    task automatic stop();
        #(HALF_NS / 2);
        host_oe = 1'b1;
        #(HALF_NS / 2);
        scl = 1'b1;
        #(HALF_NS);
        host_oe = 1'b0;
        #(HALF_NS);
    endtask

    // Data changes mid-low and is sampled mid-high, so neither side races the edge
    task automatic bit_io(input logic d, output logic s);
        #(HALF_NS / 2);
        host_oe = ~d;
        #(HALF_NS / 2);
        scl = 1'b1;
        #(HALF_NS / 2);
        s = sda;
        #(HALF_NS / 2);
        scl = 1'b0;
    endtask

    // Only address or ignored-write bytes are sent, most significant bit first
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Caller passes ack low on the last byte of a block
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(~ack, s);
    endtask

endmodule // sbr_host_model

// file: verif/sbr_block_read_test.sv
// Purpose: Self-checking bench for the block-read responder
// Assumes: Buffer memory modelled here with a one-cycle read answer
// Notes: Core inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module sbr_block_read_test;

    logic        clk;
    logic        reset_n;
    logic        scl;
    logic        host_oe;
    logic        sda_oe;
    logic        sda_o;
    logic        load_done;
    logic        mem_rd;
    logic        rd_q;
    logic [9:0]  mem_addr;
    logic [9:0]  addr_q;
    logic [7:0]  mem_rdata;
    logic [7:0]  max_blk;
    logic [10:0] buf_len;
    wire logic   sda;
    int          n_fail;
    int          check_count;

    // Open-drain wire with pull-up
    assign sda = ~(host_oe | sda_oe);

    sbr_block_read i_dut (
        .clk                 (clk),
        .reset_n             (reset_n),
        .scl_clk             (scl),
        .scl_i               (scl),
        .sda_i               (sda),
        .sda_o               (sda_o),
        .sda_oe              (sda_oe),
        .buf_len             (buf_len),
        .max_read_block_size (max_blk),
        .load_done           (load_done),
        .mem_rd              (mem_rd),
        .mem_addr            (mem_addr),
        .mem_rdata           (mem_rdata)
    );

    sbr_host_model i_host (
        .scl     (scl),
        .host_oe (host_oe),
        .sda     (sda)
    );

    function automatic logic [7:0] pat(input int a);
        return 8'(a * 37 + 5);
    endfunction

    // Read data is only good the cycle after a read; otherwise it flips so stale use shows
    always @(posedge clk) begin
        rd_q   = mem_rd;
        addr_q = mem_addr;
        #1 mem_rdata = rd_q ? pat(int'(addr_q)) : ~mem_rdata;
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic block_read(input logic [6:0] a, input logic pre, input int first, input int cnt,
                              input int take);
        logic       ack;
        logic [7:0] b;
        if (pre) begin
            i_host.start();
            i_host.send_byte({a, 1'b0}, ack);
            check("write address ack", 32'h1, 32'(ack));
            i_host.send_byte(8'h7f, ack);
            check("ignore code ack", 32'h1, 32'(ack));
        end
        i_host.start();
        i_host.send_byte({a, 1'b1}, ack);
        check("read address ack", 32'h1, 32'(ack));
        i_host.recv_byte(take > 0, b);
        check("count", 32'(cnt), 32'(b));
        for (int i = 0; i < take; i++) begin
            i_host.recv_byte(i < take - 1, b);
            check("data", 32'(pat(first + i)), 32'(b));
        end
        i_host.stop();
        check("sda drive level", 32'h0, 32'(sda_o));
    endtask

    task automatic s_first_block();
        block_read(sbr_pkg::SLV_ADDR_FIRST, 1'b0, 0, 4, 4);
    endtask

    task automatic s_continue_prewrite();
        block_read(sbr_pkg::SLV_ADDR_CONT, 1'b1, 4, 1, 1);
    endtask

    // Early NACK leaves the pointer after the last byte delivered
    task automatic s_wrap_and_abort();
        block_read(sbr_pkg::SLV_ADDR_CONT, 1'b0, 0, 4, 2);
        block_read(sbr_pkg::SLV_ADDR_CONT, 1'b0, 2, 3, 3);
    endtask

    task automatic s_fresh_after_load();
        block_read(sbr_pkg::SLV_ADDR_CONT, 1'b0, 0, 4, 1);
        @(posedge clk);
        #1 load_done = 1'b1;
        @(posedge clk);
        #1 load_done = 1'b0;
        block_read(sbr_pkg::SLV_ADDR_CONT, 1'b0, 0, 4, 4);
    endtask

    task automatic s_refused_and_limits();
        logic ack;
        i_host.start();
        i_host.send_byte(8'h55, ack);
        check("foreign address ack", 32'h0, 32'(ack));
        i_host.stop();
        @(posedge clk);
        #1 max_blk = 8'h08;
        block_read(sbr_pkg::SLV_ADDR_FIRST, 1'b1, 0, 5, 5);
        @(posedge clk);
        #1 buf_len = 11'h000;
        block_read(sbr_pkg::SLV_ADDR_FIRST, 1'b0, 0, 0, 0);
    endtask

    initial begin
        n_fail      = 0;
        check_count = 0;
        reset_n     = 1'b0;
        load_done   = 1'b0;
        mem_rdata   = 8'h00;
        max_blk     = 8'h04;
        buf_len     = 11'h005;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (8) @(posedge clk);
        s_first_block();
        s_continue_prewrite();
        s_wrap_and_abort();
        s_fresh_after_load();
        s_refused_and_limits();
        end_of_test();
    end

    // About 41 bytes at 18 us each; over twice that cuts a hang
    initial begin
        #2000000;
        n_fail++;
        end_of_test();
    end

endmodule // sbr_block_read_test
